/* File: design/twc_ctrl.sv */
// Purpose: Byte-level two-wire master/slave controller with APB register access
// Assumes: Pins are open drain and pulled up outside; GPIO logic supplies its own drive
// Notes:   Overview of operation below; one interrupt pulse per event
//
// Overview of operation
// - Enable routes two pins to open-drain serial use; otherwise plain GPIO.
// - Setting master issues start, then sends the data register byte.
// - Later master bytes start only when firmware writes continue.
// - Master drives clock and data, arbitrates and follows clock stretching.
// - Lost arbitration clears master, sets arbitration-lost, raises interrupt.
// - After lost arbitration the interrupt waits until the external transaction ends.
// - Firmware clearing master from one to zero sends a stop.
// - Continue reads one while busy; status writes are ignored while busy.
// - After a byte interrupt the block stays idle until firmware writes continue, clears master or clears enable.
// - Transmit select one sends data, zero receives, master or slave.
// - First byte after start or restart is always transmitted as master and always received as slave.
// - Receiving, acknowledge bit one pulls data low in the acknowledge slot.
// - Transmitting, acknowledge bit reports whether the receiver acknowledged.
// - Address flag set on slave first byte or lost arbitration; continue clears.
// - Hardware clears the restart bit during the restart sequence.
// - Stop flag set on stop in slave receive, unless firmware declined acknowledge.
// - Interrupt after each byte, slave-receive stop and lost arbitration.
// - While firmware decides, the clock line is held low.
// - Clock on bit 0, data on bit 1 of port 1 or 2 per configuration.
// - Received byte and byte to transmit are separate registers.
`timescale 1ns/1ps
`include "twc_cfg.svh"
module twc_ctrl #(
	parameter int SCL_HALF = `TWC_SCL_HALF_CYC
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  p1In,
	input  wire logic [1:0]  p2In,
	input  wire logic [1:0]  gpioP1Out,
	input  wire logic [1:0]  gpioP1Oe,
	input  wire logic [1:0]  gpioP2Out,
	input  wire logic [1:0]  gpioP2Oe,
	output logic      [1:0]  p1Out,
	output logic      [1:0]  p1Oe,
	output logic      [1:0]  p2Out,
	output logic      [1:0]  p2Oe,
	output logic             twcIrq
);
	import twc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	twc_ctrl_t  ctrl_q;
	twc_ctrl_t  wr;
	twc_drv_t   drv_q;
	twc_state_t state_q;
	logic [7:0]  cfg_q;
	logic [7:0]  txData_q;
	logic [7:0]  rxData_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_q;
	logic [1:0]  step_q;
	logic [15:0] cnt_q;
	logic        txMode_q;
	logic        noAck_q;
	logic        busBusy_q;
	logic        irq_q;
	logic [31:0] prdata_q;
	logic [3:0]  pinSync;
	logic        sclS;
	logic        sdaS;
	logic        sclPrev_q;
	logic        sdaPrev_q;
	logic        onP2;
	logic        sclRise;
	logic        sclFall;
	logic        startDet;
	logic        stopDet;
	logic        access;
	logic        hit;
	logic        stWr;
	logic        halfDone;

	function automatic logic [11:0] regAddr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// APB slave: zero wait states, error on unmapped address
	// ----------------------------------------------------------------
	assign access  = psel && penable;
	assign hit     = (paddr == regAddr(`TWC_IDX_STATUS)) || (paddr == regAddr(`TWC_IDX_DATA))
	              || (paddr == regAddr(`TWC_IDX_CFG));
	assign pready  = 1'b1;
	assign pslverr = access && !hit;
	assign prdata  = prdata_q;
	assign wr      = twc_ctrl_t'(pwdata[7:0]);
	// Status writes are locked while a transaction is in flight
	assign stWr    = access && pwrite && (paddr == regAddr(`TWC_IDX_STATUS)) && !ctrl_q.cont;

	// Read data captured in the setup cycle so it stands for the access cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == regAddr(`TWC_IDX_STATUS)) begin
				prdata_q <= {24'h00_0000, ctrl_q};
			end else if (paddr == regAddr(`TWC_IDX_DATA)) begin
				prdata_q <= {24'h00_0000, rxData_q};
			end else if (paddr == regAddr(`TWC_IDX_CFG)) begin
				prdata_q <= {24'h00_0000, cfg_q};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= `TWC_CFG_RST;
		end else if (access && pwrite && paddr == regAddr(`TWC_IDX_CFG)) begin
			cfg_q <= pwdata[7:0] & `TWC_CFG_WMASK;
		end
	end

	// Write side of the data register never disturbs the received byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txData_q <= 8'h00;
		end else if (access && pwrite && paddr == regAddr(`TWC_IDX_DATA)) begin
			txData_q <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Pins: synchronise, select port, open-drain override
	// ----------------------------------------------------------------
	twc_sync #(
		.WIDTH (4)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.din  ({p2In, p1In}),
		.dout (pinSync)
	);

	assign onP2 = cfg_q[`TWC_CFG_POS_BIT] || cfg_q[`TWC_CFG_W1_BIT];
	assign sclS = onP2 ? pinSync[2] : pinSync[0];
	assign sdaS = onP2 ? pinSync[3] : pinSync[1];

	// Open drain while enabled: the serial pins are only ever driven low; other pins follow GPIO
	assign p1Out = (ctrl_q.en && !onP2) ? 2'b00 : gpioP1Out;
	assign p1Oe  = (ctrl_q.en && !onP2) ? {drv_q.sdaLow, drv_q.sclLow} : gpioP1Oe;
	assign p2Out = (ctrl_q.en && onP2) ? 2'b00 : gpioP2Out;
	assign p2Oe  = (ctrl_q.en && onP2) ? {drv_q.sdaLow, drv_q.sclLow} : gpioP2Oe;

	// ----------------------------------------------------------------
	// Bus condition detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	assign sclRise  = sclS && !sclPrev_q;
	assign sclFall  = !sclS && sclPrev_q;
	assign startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopDet  = sclS && sclPrev_q && !sdaPrev_q && sdaS;
	assign halfDone = (cnt_q == 16'(SCL_HALF - 1));
	assign twcIrq   = irq_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busBusy_q <= 1'b0;
		end else if (startDet) begin
			busBusy_q <= 1'b1;
		end else if (stopDet) begin
			busBusy_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Controller state, flags and shifter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q   <= twc_ctrl_t'(`TWC_CTRL_RST);
			state_q  <= ST_IDLE;
			drv_q    <= '0;
			shift_q  <= 8'h00;
			rxData_q <= 8'h00;
			bit_q    <= 4'h0;
			step_q   <= 2'b00;
			cnt_q    <= 16'h0000;
			txMode_q <= 1'b0;
			noAck_q  <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			irq_q <= 1'b0;
			if (stWr) begin
				ctrl_q.en     <= wr.en;
				ctrl_q.master <= wr.master;
				ctrl_q.xmit   <= wr.xmit;
				ctrl_q.ack    <= wr.ack;
				ctrl_q.arb    <= wr.arb;
				// Address flag can only be cleared by software
				ctrl_q.addr   <= wr.cont ? 1'b0 : (ctrl_q.addr & wr.addr);
				if (wr.cont) begin
					ctrl_q.stop <= 1'b0;
				end
			end
			case (state_q)
				ST_IDLE: begin
					drv_q <= '0;
					if (stWr && wr.en && wr.master && !ctrl_q.master) begin
						state_q     <= ST_START;
						ctrl_q.cont <= 1'b1;
						step_q      <= 2'b00;
						cnt_q       <= 16'h0000;
					end else if (ctrl_q.en && !ctrl_q.master && startDet) begin
						state_q     <= ST_SBIT;
						ctrl_q.addr <= 1'b1;
						ctrl_q.cont <= 1'b1;
						txMode_q    <= 1'b0;
						noAck_q     <= 1'b0;
						bit_q       <= 4'h0;
					end
				end
				ST_START: begin
					// Wait for a free bus, then pull data low under a high clock
					if (step_q == 2'b00) begin
						if (!busBusy_q && sclS && sdaS) begin
							drv_q.sdaLow <= 1'b1;
							step_q       <= 2'b01;
							cnt_q        <= 16'h0000;
						end
					end else if (halfDone) begin
						state_q      <= ST_MBIT;
						drv_q.sclLow <= 1'b1;
						drv_q.sdaLow <= ~txData_q[7];
						shift_q      <= txData_q;
						txMode_q     <= 1'b1;
						bit_q        <= 4'h0;
						step_q       <= 2'b00;
						cnt_q        <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				ST_RSTART, ST_STOP: begin
					// Step 0 clock low, step 1 clock high, step 2 data edge
					if (step_q == 2'b01 && !sclS) begin
						cnt_q <= 16'h0000;
					end else if (!halfDone) begin
						cnt_q <= cnt_q + 16'h0001;
					end else begin
						cnt_q  <= 16'h0000;
						step_q <= step_q + 2'b01;
						if (step_q == 2'b00) begin
							drv_q.sclLow <= 1'b0;
						end else if (step_q == 2'b01) begin
							drv_q.sdaLow <= (state_q == ST_RSTART);
						end else if (state_q == ST_STOP) begin
							state_q     <= ST_IDLE;
							ctrl_q.cont <= 1'b0;
						end else begin
							state_q      <= ST_MBIT;
							drv_q.sclLow <= 1'b1;
							drv_q.sdaLow <= ~txData_q[7];
							shift_q      <= txData_q;
							txMode_q     <= 1'b1;
							bit_q        <= 4'h0;
							step_q       <= 2'b00;
						end
					end
				end
				ST_MBIT: begin
					if (step_q == 2'b00) begin
						if (halfDone) begin
							drv_q.sclLow <= 1'b0;
							step_q       <= 2'b01;
							cnt_q        <= 16'h0000;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end else if (!sclS) begin
						cnt_q <= 16'h0000;
					end else if (bit_q < 4'h8 && txMode_q && !drv_q.sdaLow && !sdaS) begin
						state_q       <= ST_ARBWAIT;
						drv_q         <= '0;
						ctrl_q.master <= 1'b0;
						ctrl_q.arb    <= 1'b1;
						ctrl_q.addr   <= 1'b1;
					end else if (halfDone) begin
						drv_q.sclLow <= 1'b1;
						step_q       <= 2'b00;
						cnt_q        <= 16'h0000;
						if (bit_q == 4'h8) begin
							if (txMode_q) begin
								ctrl_q.ack <= ~sdaS;
							end
							drv_q.sdaLow <= 1'b0;
							state_q      <= ST_HOLD;
							ctrl_q.cont  <= 1'b0;
							irq_q        <= 1'b1;
						end else begin
							shift_q <= {shift_q[6:0], sdaS};
							bit_q   <= bit_q + 4'h1;
							if (bit_q == 4'h7) begin
								rxData_q     <= {shift_q[6:0], sdaS};
								drv_q.sdaLow <= !txMode_q && ctrl_q.ack;
							end else begin
								drv_q.sdaLow <= txMode_q && !shift_q[6];
							end
						end
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				ST_SBIT: begin
					if (startDet) begin
						ctrl_q.addr <= 1'b1;
						txMode_q    <= 1'b0;
						noAck_q     <= 1'b0;
						bit_q       <= 4'h0;
						drv_q       <= '0;
					end else if (stopDet) begin
						state_q     <= ST_IDLE;
						drv_q       <= '0;
						ctrl_q.cont <= 1'b0;
						if (!txMode_q && !noAck_q) begin
							ctrl_q.stop <= 1'b1;
							irq_q       <= 1'b1;
						end
					end else if (sclRise) begin
						if (bit_q < 4'h8) begin
							shift_q <= {shift_q[6:0], sdaS};
						end else if (txMode_q) begin
							ctrl_q.ack <= ~sdaS;
						end
					end else if (sclFall) begin
						if (bit_q < 4'h7) begin
							bit_q        <= bit_q + 4'h1;
							drv_q.sdaLow <= txMode_q && !shift_q[7];
						end else if (bit_q == 4'h7) begin
							rxData_q     <= shift_q;
							bit_q        <= 4'h8;
							drv_q.sdaLow <= 1'b0;
							if (!txMode_q) begin
								drv_q.sclLow <= 1'b1;
								state_q      <= ST_HOLD;
								ctrl_q.cont  <= 1'b0;
								irq_q        <= 1'b1;
							end
						end else if (txMode_q) begin
							drv_q.sclLow <= 1'b1;
							state_q      <= ST_HOLD;
							ctrl_q.cont  <= 1'b0;
							irq_q        <= 1'b1;
						end else begin
							drv_q.sdaLow <= 1'b0;
							bit_q        <= 4'h0;
							if (noAck_q) begin
								state_q     <= ST_IDLE;
								ctrl_q.cont <= 1'b0;
							end else if (ctrl_q.xmit) begin
								txMode_q     <= 1'b1;
								shift_q      <= txData_q;
								drv_q.sdaLow <= ~txData_q[7];
							end
						end
					end
				end
				ST_HOLD: begin
					// Nothing moves until firmware answers the interrupt
					if (stWr && !wr.en) begin
						state_q <= ST_IDLE;
						drv_q   <= '0;
					end else if (stWr && ctrl_q.master && !wr.master) begin
						// Data low under the held clock, so its later release is the stop
						state_q      <= ST_STOP;
						ctrl_q.cont  <= 1'b1;
						drv_q.sdaLow <= 1'b1;
						step_q       <= 2'b00;
						cnt_q        <= 16'h0000;
					end else if (stWr && wr.cont && ctrl_q.master && wr.arb) begin
						// Data released first so the clock rises under a high data line
						state_q      <= ST_RSTART;
						ctrl_q.arb   <= 1'b0;
						ctrl_q.cont  <= 1'b1;
						drv_q.sdaLow <= 1'b0;
						step_q       <= 2'b00;
						cnt_q        <= 16'h0000;
					end else if (stWr && wr.cont && ctrl_q.master) begin
						state_q      <= ST_MBIT;
						ctrl_q.cont  <= 1'b1;
						txMode_q     <= wr.xmit;
						shift_q      <= wr.xmit ? txData_q : 8'hFF;
						drv_q.sdaLow <= wr.xmit && !txData_q[7];
						bit_q        <= 4'h0;
						step_q       <= 2'b00;
						cnt_q        <= 16'h0000;
					end else if (stWr && wr.cont && !txMode_q) begin
						state_q      <= ST_SBIT;
						ctrl_q.cont  <= 1'b1;
						drv_q.sclLow <= 1'b0;
						drv_q.sdaLow <= wr.ack;
						noAck_q      <= !wr.ack;
					end else if (stWr && wr.cont && ctrl_q.ack && wr.xmit) begin
						state_q      <= ST_SBIT;
						ctrl_q.cont  <= 1'b1;
						shift_q      <= txData_q;
						bit_q        <= 4'h0;
						drv_q.sclLow <= 1'b0;
						drv_q.sdaLow <= ~txData_q[7];
					end else if (stWr && wr.cont) begin
						state_q <= ST_IDLE;
						drv_q   <= '0;
					end
				end
				ST_ARBWAIT: begin
					// Winner's transfer runs to its stop before firmware hears of the loss
					if (stopDet) begin
						state_q     <= ST_IDLE;
						ctrl_q.cont <= 1'b0;
						irq_q       <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					drv_q   <= '0;
				end
			endcase
		end
	end
endmodule

/* File: include/twc_cfg.svh */
// Purpose: Constants for the two-wire controller: register indices, field positions, timing
// Assumes: 250 MHz system clock
// Notes:   Byte address of a register is four times its index
`ifndef TWC_CFG_SVH
`define TWC_CFG_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define TWC_IDX_CFG      8'h09
`define TWC_IDX_STATUS   8'h28
`define TWC_IDX_DATA     8'h29

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TWC_CFG_POS_BIT  7
`define TWC_CFG_W1_BIT   1
`define TWC_CFG_WMASK    8'hB3
`define TWC_CTRL_RST     8'h00
`define TWC_CFG_RST      8'h00

// ----------------------------------------------------------------
// Timing: half period of a 100 kHz serial clock
// ----------------------------------------------------------------
`define TWC_CLK_MHZ      250
`define TWC_SCL_HALF_NS  5000
`define TWC_SCL_HALF_CYC ((`TWC_SCL_HALF_NS * `TWC_CLK_MHZ) / 1000)

`endif

/* File: include/twc_pkg.sv */
// Purpose: Types shared by the two-wire controller files
// Assumes: Nothing beyond the cfg header
// Notes:   Control struct follows the status/control bit order, msb first
package twc_pkg;

	// ----------------------------------------------------------------
	// Status/control register layout
	// ----------------------------------------------------------------
	typedef struct packed {
		logic master;
		logic cont;
		logic xmit;
		logic ack;
		logic addr;
		logic arb;
		logic stop;
		logic en;
	} twc_ctrl_t;

	// ----------------------------------------------------------------
	// Open-drain pin pair: drive-low requests
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sdaLow;
		logic sclLow;
	} twc_drv_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_RSTART,
		ST_MBIT,
		ST_STOP,
		ST_SBIT,
		ST_HOLD,
		ST_ARBWAIT
	} twc_state_t;

endpackage

/* File: design/twc_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
module twc_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '1;
			dout   <= '1;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* File: verification/twc_ctrl_sva.sv */
// Purpose: Port-level checker for the two-wire controller
// Assumes: Pins on port 1; serial clock shortened to a few cycles
// Notes:   Delay windows suit a short SCL_HALF, not the 100 kHz default
`timescale 1ns/1ps
module twc_ctrl_sva #(
	parameter int SCL_HALF = 1250
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  p1In,
	input wire logic [1:0]  p2In,
	input wire logic [1:0]  gpioP1Out,
	input wire logic [1:0]  gpioP1Oe,
	input wire logic [1:0]  gpioP2Out,
	input wire logic [1:0]  gpioP2Oe,
	input wire logic [1:0]  p1Out,
	input wire logic [1:0]  p1Oe,
	input wire logic [1:0]  p2Out,
	input wire logic [1:0]  p2Oe,
	input wire logic        twcIrq
);
	// ----
	// Shadows of enable and pin position
	// ----
	logic enSeen;
	logic cfgP2;
	logic wrSt;
	assign wrSt = psel && penable && pwrite && paddr == 12'h0A0;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) enSeen <= 1'b0;
		else if (wrSt && pwdata[0]) enSeen <= 1'b1;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cfgP2 <= 1'b0;
		else if (psel && penable && pwrite && paddr == 12'h024) cfgP2 <= pwdata[7] | pwdata[1];
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_pready_high: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	a_unmapped_err: assert property (psel && penable |->
		pslverr == !(paddr inside {12'h024, 12'h0A0, 12'h0A4}))
		else $error("pslverr wrong for address");
	a_gpio_p1: assert property (!enSeen |-> p1Oe == gpioP1Oe && p1Out == gpioP1Out)
		else $error("port 1 not following gpio");
	a_gpio_p2: assert property (!cfgP2 |-> p2Oe == gpioP2Oe && p2Out == gpioP2Out)
		else $error("port 2 not following gpio");
	a_irq_pulse: assert property (twcIrq |=> !twcIrq)
		else $error("interrupt longer than one cycle");
	a_start_sent: assert property (wrSt && pwdata[7:0] == 8'h81 && p1In == 2'b11 && !cfgP2
		|-> ##[1:200] (p1Oe == 2'b10))
		else $error("no start after master set");
	a_stop_sent: assert property (wrSt && pwdata[7:0] == 8'h01 && p1Oe == 2'b01
		|-> ##[1:200] (p1In[0] && $rose(p1In[1])))
		else $error("no stop after master cleared");
	a_clock_held: assert property (twcIrq && !p1In[0] |=> p1Oe[0] [*8])
		else $error("clock released while waiting");
	c_irq: cover property (twcIrq);
	c_err: cover property (pslverr);
	c_stop: cover property (p1In[0] && $rose(p1In[1]));
endmodule

bind twc_ctrl twc_ctrl_sva #(.SCL_HALF(SCL_HALF)) u_sva (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .p1In(p1In), .p2In(p2In), .gpioP1Out(gpioP1Out),
	.gpioP1Oe(gpioP1Oe), .gpioP2Out(gpioP2Out), .gpioP2Oe(gpioP2Oe), .p1Out(p1Out),
	.p1Oe(p1Oe), .p2Out(p2Out), .p2Oe(p2Oe), .twcIrq(twcIrq));

/* File: verification/twc_bus_model.sv */
// Purpose: Far-side two-wire device: receives and acknowledges, or sends
// Assumes: Lines are wired-AND with pull-ups in the bench
// Notes:   Stops sending after a refused acknowledge, as a real slave must
`timescale 1ns/1ps
module twc_bus_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       sendMode,
	input  wire logic [7:0] txByte,
	output logic            sdaLow,
	output logic      [7:0] rxByte,
	output logic            ackSeen,
	output logic            stopSeen,
	output int              sclFalls
);
	int   cnt;
	logic nackd;
	initial begin
		cnt = 9;
		nackd = 1'b0;
		rxByte = 8'h00;
		ackSeen = 1'b1;
		stopSeen = 1'b0;
		sclFalls = 0;
	end
	// Clock is looked at a little later: data may move in the time step the clock falls
	always @(negedge sda) begin
		#1;
		if (scl) begin
			cnt = -1;
			nackd = 1'b0;
			stopSeen = 1'b0;
		end
	end
	always @(posedge sda) begin
		#1;
		if (scl) begin
			cnt = 9;
			stopSeen = 1'b1;
		end
	end
	always @(posedge scl) begin
		if (cnt >= 0 && cnt < 8) rxByte = {rxByte[6:0], sda};
		else if (cnt == 8) begin
			ackSeen = sda;
			nackd = sda;
		end
	end
	always @(negedge scl) begin
		sclFalls++;
		if (cnt < 9) cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// Data changes only while the clock is low
	assign sdaLow = sendMode ? (!nackd && cnt >= 0 && cnt < 8 && !txByte[7 - cnt]) : (cnt == 8);
endmodule

/* File: verification/twc_ctrl_tb.sv */
// Purpose: Self-checking bench for the two-wire controller
// Assumes: Serial pins on port 1; short serial clock
// Notes:   Register table first, then a full master transaction
`timescale 1ns/1ps
module twc_ctrl_tb;
	import twc_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} twc_row_t;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, twcIrq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  p1In, p1Out, p1Oe, p2Out, p2Oe, gOut, gOe;
	logic        sdaLow, ackSeen, stopSeen, sendMode;
	logic [7:0]  rxByte, txByte;
	int          sclFalls, errors, cmpCount, n0;
	twc_row_t    rows [9];
	// Open-drain lines with pull-ups
	assign p1In[0] = !(p1Oe[0] && !p1Out[0]);
	assign p1In[1] = !(p1Oe[1] && !p1Out[1]) && !sdaLow;
	twc_ctrl #(.SCL_HALF(6)) dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p1In(p1In), .p2In(2'b11), .gpioP1Out(gOut), .gpioP1Oe(gOe),
		.gpioP2Out(gOut), .gpioP2Oe(gOe), .p1Out(p1Out), .p1Oe(p1Oe), .p2Out(p2Out),
		.p2Oe(p2Oe), .twcIrq(twcIrq));
	twc_bus_model peer (.scl(p1In[0]), .sda(p1In[1]), .sendMode(sendMode), .txByte(txByte),
		.sdaLow(sdaLow), .rxByte(rxByte), .ackSeen(ackSeen), .stopSeen(stopSeen),
		.sclFalls(sclFalls));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		cmpCount++;
		if (s !== x) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task end_of_test;
		if (errors == 0 && cmpCount > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Holds the request until pready is sampled high, then idles one cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			end_of_test;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitHi(input bit stop);
		int n;
		n = 0;
		while ((stop ? stopSeen : twcIrq) !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000) begin
			errors++;
			end_of_test;
		end
		@(posedge clk);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		gOut = 2'b10;
		gOe = 2'b11;
		sendMode = 1'b0;
		txByte = 8'h00;
		errors = 0;
		cmpCount = 0;
		rows = '{'{1'b0, 12'h0A0, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h024, 32'h0, 32'h0, 1'b0},
			'{1'b1, 12'h024, 32'hFF, 32'h0, 1'b0}, '{1'b0, 12'h024, 32'h0, 32'hB3, 1'b0},
			'{1'b1, 12'h024, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h024, 32'h0, 32'h0, 1'b0},
			'{1'b0, 12'h030, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h0A4, 32'hA6, 32'h0, 1'b0},
			'{1'b0, 12'h0A4, 32'h0, 32'h0, 1'b0}};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("rdata", rd, rows[i].x);
			chk("slverr", {31'h0, er}, {31'h0, rows[i].e});
		end
		chk("gpioPass", {28'h0, p1Out, p1Oe}, {28'h0, gOut, gOe});
		apb(1'b1, 12'h0A0, 32'h01);
		chk("openDrain", {28'h0, p1Out, p1Oe}, 32'h0);
		apb(1'b1, 12'h0A0, 32'h81);
		apb(1'b0, 12'h0A0, 32'h0);
		chk("busy", rd & 32'h40, 32'h40);
		// Locked out: must not clear master mid-byte
		apb(1'b1, 12'h0A0, 32'h0);
		waitHi(1'b0);
		chk("addrByte", {24'h0, rxByte}, 32'hA6);
		apb(1'b0, 12'h0A0, 32'h0);
		chk("status", rd & 32'hD1, 32'h91);
		n0 = sclFalls;
		repeat (40) @(posedge clk);
		chk("hold", sclFalls, n0);
		txByte <= 8'h3C;
		sendMode <= 1'b1;
		apb(1'b1, 12'h0A0, 32'hD1);
		waitHi(1'b0);
		chk("ackDriven", {31'h0, ackSeen}, 32'h0);
		apb(1'b0, 12'h0A4, 32'h0);
		chk("rxData", rd, 32'h3C);
		txByte <= 8'hC3;
		apb(1'b1, 12'h0A0, 32'hC1);
		waitHi(1'b0);
		chk("ackReleased", {31'h0, ackSeen}, 32'h1);
		apb(1'b0, 12'h0A4, 32'h0);
		chk("rxData2", rd, 32'hC3);
		// Restart: new address loaded before restart, continue and master are set
		sendMode <= 1'b0;
		apb(1'b1, 12'h0A4, 32'h5B);
		apb(1'b1, 12'h0A0, 32'hC5);
		waitHi(1'b0);
		chk("restartAddr", {24'h0, rxByte}, 32'h5B);
		apb(1'b0, 12'h0A0, 32'h0);
		chk("restartClr", rd & 32'hD4, 32'h90);
		apb(1'b1, 12'h0A0, 32'h01);
		waitHi(1'b1);
		chk("stop", {31'h0, stopSeen}, 32'h1);
		apb(1'b0, 12'h0A0, 32'h0);
		chk("masterOff", rd & 32'h80, 32'h0);
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h0A0, 32'h0);
		chk("resetAgain", rd, 32'h0);
		apb(1'b1, 12'h024, 32'h02);
		apb(1'b1, 12'h0A0, 32'h01);
		chk("port2", {24'h0, p2Out, p2Oe, p1Out, p1Oe}, {24'h0, 4'h0, gOut, gOe});
		end_of_test;
	end
endmodule
